// ===== hdl/nsr_host.sv
// Host sequencer that polls status, reads identification and resets a
// multi-plane NAND flash over its pins. Assumes pins synchronous to SYS_CLK.
//
// How it works
// - Reissue read command after status mid-read (host only sets relook; the READ op sends 00h)
// - Multi-plane status uses the 71h command
// - Trust pass/fail only when device ready
// - Plane bits only valid under 71h
// - Bit five is reserved, ignored
// - Identify: 90h, address 00h, four reads
// - Ignore third ID byte; C0h means multi-plane
// - Wait 10us after power-up before commands
`timescale 1ns/100ps
`default_nettype none
`include "nsr_map.svh"

module nsr_host (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic CE_N,
  output logic CLE,
  output logic ALE,
  output logic WE_N,
  output logic OUTPUT_STROBE_N,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_N,
  input wire logic RB_N,
  output logic WP_N
);

  nsr_pkg::nsr_regs_t r;
  nsr_pkg::nsr_regs_t n;
  logic ph_end;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [2:0] nsr_reads(input logic [2:0] op);
    case (op)
      `NSR_OP_STAT, `NSR_OP_MSTAT: nsr_reads = 3'h1;
      `NSR_OP_ID: nsr_reads = 3'h4;
      default: nsr_reads = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] nsr_cmd_byte(input logic [2:0] op);
    case (op)
      `NSR_OP_STAT: nsr_cmd_byte = `NSR_CB_STAT;
      `NSR_OP_MSTAT: nsr_cmd_byte = `NSR_CB_MSTAT;
      `NSR_OP_ID: nsr_cmd_byte = `NSR_CB_ID;
      `NSR_OP_RST: nsr_cmd_byte = `NSR_CB_RST;
      default: nsr_cmd_byte = `NSR_CB_READ;
    endcase
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  assign ph_end = (r.cnt == 10'(`NSR_PH_CYC - 1));

  always_comb begin
    n = r;
    n.cnt = r.cnt + 10'h001;
    n.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        `NSR_OFS_CTRL: n.rdata = {7'h00, r.wp_n};
        `NSR_OFS_FLAGS: n.rdata = {2'h0, r.wp_n, r.relook, r.pf_ok, (r.id3 == `NSR_MULTI_CODE), RB_N,
                                   (r.st != nsr_pkg::S_IDLE)};
        `NSR_OFS_STATUS: n.rdata = r.sres;
        `NSR_OFS_ID0: n.rdata = r.id0;
        `NSR_OFS_ID1: n.rdata = r.id1;
        `NSR_OFS_ID2: n.rdata = 8'h00;
        `NSR_OFS_ID3: n.rdata = r.id3;
        default: n.rdata = 8'h00;
      endcase
    end
    if (WR && ADDR == `NSR_OFS_CTRL) begin
      n.wp_n = WDATA[0];
    end
    case (r.st)
      nsr_pkg::S_PWR: begin
        if (r.cnt == 10'(`NSR_PWR_CYC - 1)) begin
          n.st = nsr_pkg::S_IDLE;
        end
      end
      nsr_pkg::S_IDLE: begin
        n.cnt = 10'h000;
        if (WR && ADDR == `NSR_OFS_CMD && WDATA[2:0] <= `NSR_OP_READ) begin
          n.op = WDATA[2:0];
          n.idx = 3'h0;
          n.ce_n = 1'b0;
          n.cle = 1'b1;
          n.dq = nsr_cmd_byte(WDATA[2:0]);
          n.dq_oe_n = 1'b0;
          n.st = nsr_pkg::S_SET;
          if (WDATA[2:0] == `NSR_OP_RST) begin
            n.pf_ok = 1'b0;
          end
        end
      end
      nsr_pkg::S_SET: begin
        if (ph_end) begin
          n.cnt = 10'h000;
          n.we_n = 1'b0;
          n.st = nsr_pkg::S_WLO;
        end
      end
      nsr_pkg::S_WLO: begin
        if (ph_end) begin
          n.cnt = 10'h000;
          n.we_n = 1'b1;
          n.st = nsr_pkg::S_WHI;
        end
      end
      nsr_pkg::S_WHI: begin
        if (ph_end) begin
          n.cnt = 10'h000;
          if (r.cle && r.op == `NSR_OP_ID) begin
            n.cle = 1'b0;
            n.ale = 1'b1;
            n.dq = `NSR_ID_ADDR;
            n.st = nsr_pkg::S_SET;
          end else begin
            n.cle = 1'b0;
            n.ale = 1'b0;
            n.dq_oe_n = 1'b1;
            if (nsr_reads(r.op) != 3'h0) begin
              n.re_n = 1'b0;
              n.st = nsr_pkg::S_RLO;
            end else if (r.op == `NSR_OP_RST) begin
              n.st = nsr_pkg::S_WB;
            end else begin
              n.relook = 1'b0;
              n.ce_n = 1'b1;
              n.st = nsr_pkg::S_IDLE;
            end
          end
        end
      end
      nsr_pkg::S_RLO: begin
        if (ph_end) begin
          n.cnt = 10'h000;
          n.re_n = 1'b1;
          n.st = nsr_pkg::S_RHI;
          if (r.op == `NSR_OP_ID) begin
            case (r.idx)
              3'h0: n.id0 = DQ_IN;
              3'h1: n.id1 = DQ_IN;
              3'h3: n.id3 = DQ_IN;
              default: n.id0 = r.id0;
            endcase
          end else begin
            n.sres = DQ_IN & ((r.op == `NSR_OP_MSTAT) ? `NSR_MASK_MSTAT : `NSR_MASK_STAT);
            n.pf_ok = DQ_IN[6];
            n.relook = 1'b1;
          end
        end
      end
      nsr_pkg::S_RHI: begin
        if (ph_end) begin
          n.cnt = 10'h000;
          if (r.idx + 3'h1 == nsr_reads(r.op)) begin
            n.ce_n = 1'b1;
            n.st = nsr_pkg::S_IDLE;
          end else begin
            n.idx = r.idx + 3'h1;
            n.re_n = 1'b0;
            n.st = nsr_pkg::S_RLO;
          end
        end
      end
      nsr_pkg::S_WB: begin
        if (r.cnt == 10'(`NSR_WB_CYC - 1)) begin
          n.st = nsr_pkg::S_RB;
        end
      end
      nsr_pkg::S_RB: begin
        n.cnt = 10'h000;
        if (RB_N) begin
          n.ce_n = 1'b1;
          n.st = nsr_pkg::S_IDLE;
        end
      end
      default: n.st = nsr_pkg::S_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      r <= '0;
      r.st <= nsr_pkg::S_PWR;
      r.ce_n <= 1'b1;
      r.we_n <= 1'b1;
      r.re_n <= 1'b1;
      r.dq_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign RDATA = r.rdata;
  assign CE_N = r.ce_n;
  assign CLE = r.cle;
  assign ALE = r.ale;
  assign WE_N = r.we_n;
  assign OUTPUT_STROBE_N = r.re_n;
  assign DQ_OUT = r.dq;
  assign DQ_OE_N = r.dq_oe_n;
  assign WP_N = r.wp_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  sequence cmd_pulse_s;
    (CLE && WE_N) [*2] ##1 (CLE && !WE_N) [*2] ##1 (CLE && WE_N) [*2];
  endsequence

  sequence id_start_s;
    r.st == nsr_pkg::S_IDLE ##1 CLE && r.op == `NSR_OP_ID;
  endsequence

  pwr_quiet_a: assert property (r.st == nsr_pkg::S_PWR |-> WE_N && !CLE && CE_N)
    else $error("Command activity during power-up wait");
  mstat_byte_a: assert property (!WE_N && CLE && r.op == `NSR_OP_MSTAT |-> DQ_OUT == 8'h71 && !DQ_OE_N)
    else $error("Multi-plane status not sent as 71h");
  id_addr_a: assert property ($rose(ALE) |-> DQ_OUT == 8'h00 ##0 (ALE && !DQ_OE_N) [*6])
    else $error("Identify address cycle wrong");
  id_cmd_seq_a: assert property (id_start_s |-> cmd_pulse_s ##1 ALE)
    else $error("Identify command not followed by address");
  id_skip_a: assert property (RD && ADDR == `NSR_OFS_ID2 |=> RDATA == 8'h00)
    else $error("Third identification byte not ignored");
  single_mask_a: assert property ($rose(OUTPUT_STROBE_N) && r.op == `NSR_OP_STAT |-> r.sres[5:1] == 5'h00)
    else $error("Plane bits kept under single-plane status");
  rsv_mask_a: assert property (r.sres[5] == 1'b0)
    else $error("Reserved status bit kept");
  pf_valid_a: assert property (r.pf_ok |-> r.sres[6])
    else $error("Pass/fail marked valid while busy");
  relook_a: assert property ($rose(OUTPUT_STROBE_N) && r.op == `NSR_OP_STAT |-> r.relook)
    else $error("Read reissue not requested after status");
  read_pulse_a: assert property ($fell(OUTPUT_STROBE_N) |-> !OUTPUT_STROBE_N [*2] ##1 OUTPUT_STROBE_N)
    else $error("Read strobe width wrong");

endmodule

`default_nettype wire

// ===== hdl/nsr_map.svh
// Register offsets, field positions, command bytes and timing counts of the
// NAND status/identify/reset host. Assumes a 100 MHz system clock.
`ifndef NSR_MAP_SVH
`define NSR_MAP_SVH

// ****************************************
// Software register offsets
// ****************************************
`define NSR_OFS_CMD 4'h0
`define NSR_OFS_CTRL 4'h1
`define NSR_OFS_FLAGS 4'h2
`define NSR_OFS_STATUS 4'h3
`define NSR_OFS_ID0 4'h4
`define NSR_OFS_ID1 4'h5
`define NSR_OFS_ID2 4'h6
`define NSR_OFS_ID3 4'h7

// ****************************************
// Operation codes in the command register
// ****************************************
`define NSR_OP_STAT 3'h0
`define NSR_OP_MSTAT 3'h1
`define NSR_OP_ID 3'h2
`define NSR_OP_RST 3'h3
`define NSR_OP_READ 3'h4

// ****************************************
// Flash command bytes and values
// ****************************************
`define NSR_CB_STAT 8'h70
`define NSR_CB_MSTAT 8'h71
`define NSR_CB_ID 8'h90
`define NSR_CB_RST 8'hFF
`define NSR_CB_READ 8'h00
`define NSR_ID_ADDR 8'h00
`define NSR_MULTI_CODE 8'hC0
`define NSR_MASK_STAT 8'hC1
`define NSR_MASK_MSTAT 8'hDF

// ****************************************
// Flag register bit positions
// ****************************************
`define NSR_FB_BUSY 0
`define NSR_FB_RB 1
`define NSR_FB_MULTI 2
`define NSR_FB_PFVALID 3
`define NSR_FB_RELOOK 4
`define NSR_FB_WP 5

// ****************************************
// Timing
// ****************************************
`define NSR_CLK_NS 10
`define NSR_PWR_US 10
`define NSR_PWR_CYC ((`NSR_PWR_US * 1000 + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_PH_NS 20
`define NSR_PH_CYC ((`NSR_PH_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_WB_NS 100
`define NSR_WB_CYC ((`NSR_WB_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)

`endif

// ===== hdl/nsr_pkg.sv
// Types of the NAND status/identify/reset host.
// Assumes nsr_map.svh for all numbers.
package nsr_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    S_PWR, S_IDLE, S_SET, S_WLO, S_WHI, S_RLO, S_RHI, S_WB, S_RB
  } nsr_state_t;

  // ****************************************
  // Whole state of the host
  // ****************************************
  typedef struct packed {
    nsr_state_t st;
    logic [9:0] cnt;
    logic [2:0] op;
    logic [2:0] idx;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic dq_oe_n;
    logic [7:0] dq;
    logic [7:0] sres;
    logic pf_ok;
    logic relook;
    logic [7:0] id0;
    logic [7:0] id1;
    logic [7:0] id3;
    logic wp_n;
    logic [7:0] rdata;
  } nsr_regs_t;

endpackage

// ===== testbench/nsr_flash.sv
// Behavioural flash device facing the host.
// Assumes pins move just after SYS_CLK edges; clk is a timebase only.
`timescale 1ns/100ps
`default_nettype none
// MAKER and DEV are arbitrary values
module nsr_flash #(parameter int RST_CYC = 50, parameter logic [7:0] MAKER = 8'h3A, DEV = 8'h5C) (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] din,
  input wire logic wp_n,
  input wire logic [3:0] pf_in,
  input wire logic [11:0] go,
  output logic [7:0] dq,
  output logic rb_low
);
  // ****************************************
  // State and outputs
  // ****************************************
  logic [3:0] fail = 4'h0;
  logic [7:0] last = 8'h00;
  logic [11:0] cnt = 12'h000;
  logic [1:0] mode = 2'h0;
  logic [1:0] idx = 2'h0;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic in_rst = 1'b0;
  logic [7:0] val;
  wire logic [31:0] idw = {8'hC0, 8'hA5, DEV, MAKER};
  assign val = (mode == 2'h3) ? idw[idx*8 +: 8] :
    {wp_n, cnt == 0, 1'b1, fail, |fail};
  assign dq = (!ce_n && !re_n) ? val : ~last;
  assign rb_low = (cnt != 0);
  always @(posedge clk) begin
    we_q <= we_n;
    re_q <= re_n;
    if (re_n && !re_q) begin
      last <= val;
      idx <= idx + 2'h1;
    end
    if (cnt != 0) cnt <= cnt - 12'h001;
    if (cnt == 1 && !in_rst) fail <= pf_in;
    if (cnt == 1) in_rst <= 1'b0;
    if (go != 0) cnt <= go;
    if (we_n && !we_q && !ce_n && ale && din == 8'h00) idx <= 2'h0;
    if (we_n && !we_q && !ce_n && cle) begin
      idx <= 2'h0;
      case (din)
        8'h70: mode <= 2'h1;
        8'h71: mode <= 2'h2;
        8'h90: mode <= 2'h3;
        8'hFF: if (!in_rst) begin
          cnt <= RST_CYC[11:0];
          in_rst <= 1'b1;
          fail <= 4'h0;
          mode <= 2'h0;
        end
        default: mode <= 2'h0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench of the flash status/identify/reset host.
// Assumes the design sources and nsr_flash are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA, DQ_OUT, fdq, d;
  logic CE_N, CLE, ALE, WE_N, OUTPUT_STROBE_N, DQ_OE_N, WP_N, rb_low;
  logic [3:0] pf = 4'h0;
  logic [11:0] go = 12'h000;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int t;
  wire logic RB_N = ~rb_low;
  wire logic [7:0] bus = !DQ_OE_N ? DQ_OUT : fdq;
  nsr_host dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CE_N(CE_N), .CLE(CLE), .ALE(ALE), .WE_N(WE_N), .OUTPUT_STROBE_N(OUTPUT_STROBE_N),
    .DQ_IN(bus), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .RB_N(RB_N), .WP_N(WP_N));
  nsr_flash flash (.clk(SYS_CLK), .ce_n(CE_N), .cle(CLE), .ale(ALE), .we_n(WE_N), .re_n(OUTPUT_STROBE_N),
    .din(bus), .wp_n(WP_N), .pf_in(pf), .go(go), .dq(fdq), .rb_low(rb_low));
  // ****************************************
  // Clock, timeout and tasks
  // ****************************************
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  task automatic op(input logic [7:0] c);
    t = cyc;
    wr(4'h0, c);
    repeat (3) @(posedge SYS_CLK);
    d = 8'h01;
    while (d[0]) rd(4'h2);
    t = cyc - t;
  endtask
  task automatic busy(input logic [11:0] n);
    @(posedge SYS_CLK);
    go <= n;
    @(posedge SYS_CLK);
    go <= 12'h000;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RESET <= 1'b0;
    wr(4'h0, 8'h02);
    rc(4'h2, 8'h01, 8'h01);
    for (int i = 0; i < 900; i++) begin
      @(posedge SYS_CLK);
      if (CE_N !== 1'b1) chk({7'h00, CE_N}, 8'h01);
    end
    d = 8'h01;
    while (d[0]) rd(4'h2);
    rc(4'h4, 8'hFF, 8'h00);
    rc(4'h8, 8'hFF, 8'h00);
    wr(4'h1, 8'h01);
    rc(4'h2, 8'h20, 8'h20);
    op(8'h02);
    rc(4'h4, 8'hFF, 8'h3A);
    rc(4'h5, 8'hFF, 8'h5C);
    rc(4'h6, 8'hFF, 8'h00);
    rc(4'h7, 8'hFF, 8'hC0);
    rc(4'h2, 8'h04, 8'h04);
    op(8'h00);
    rc(4'h3, 8'hFF, 8'hC0);
    rc(4'h2, 8'h18, 8'h18);
    op(8'h04);
    rc(4'h2, 8'h10, 8'h00);
    pf <= 4'b0101;
    busy(12'h0C8);
    op(8'h01);
    rc(4'h3, 8'hFF, 8'h80);
    rc(4'h2, 8'h0A, 8'h00);
    repeat (250) @(posedge SYS_CLK);
    op(8'h01);
    rc(4'h3, 8'hFF, 8'hCB);
    op(8'h00);
    rc(4'h3, 8'hFF, 8'hC1);
    wr(4'h1, 8'h00);
    op(8'h00);
    rc(4'h3, 8'hFF, 8'h41);
    wr(4'h1, 8'h01);
    busy(12'h7D0);
    op(8'h00);
    rc(4'h3, 8'hFF, 8'h81);
    op(8'h03);
    chk(8'(t >= 50 && t < 400), 8'h01);
    rc(4'h2, 8'h02, 8'h02);
    op(8'h01);
    rc(4'h3, 8'hFF, 8'hC0);
    op(8'h03);
    chk(8'(t >= 50), 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
